// *** rtl/ext_bus_pins.sv ***
`timescale 1ns/1ns
module ext_bus_pins
	import ext_bus_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              ce,
	input  wire bus_req_t          req,
	input  wire logic              req_valid,
	output logic                   req_ready,
	output logic [DATA_W-1:0]      rd_data,
	output logic                   rd_valid,
	input  wire logic              bank_switch_wr,
	input  wire logic              bank_switch_keeper,
	output logic                   bus_keeper_enable,
	input  wire logic              hold_req_n,
	input  wire logic              output_float_n,
	input  wire logic              chip_reset_n,
	input  wire logic [DATA_W-1:0] data_in,
	output logic [LO_W-1:0]        addr_lo_out,
	output logic                   addr_lo_oe,
	output logic [HI_W-1:0]        addr_hi_out,
	output logic                   addr_hi_oe,
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe,
	output logic [DATA_W-1:0]      keep_out,
	output logic                   keep_en,
	output logic                   irq_accept_n,
	output logic                   irq_accept_oe,
	output logic                   bus_grant_n,
	output logic                   bus_grant_oe
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	typedef enum {st_idle, st_access, st_hold} state_t;

	logic [2:0]        ctl_s;
	logic [DATA_W-1:0] data_s;
	logic              hold_s;
	logic              float_s;
	logic              crst_s;

	initial
	begin
		if (ACCESS_CYCLES < SYNC_STAGES + 1 || ACCESS_CYCLES > 16)
			$error("access length outside what the sequencer serves");
	end

	pin_sync #(.WIDTH(3)) u_ctl_sync
	(
		.clock   (clock),
		.rstn    (rstn),
		.ce      (ce),
		.din     ({hold_req_n, output_float_n, chip_reset_n}),
		.dout    (ctl_s)
	);

	pin_sync #(.WIDTH(DATA_W)) u_data_sync
	(
		.clock   (clock),
		.rstn    (rstn),
		.ce      (ce),
		.din     (data_in),
		.dout    (data_s)
	);

	// Synchroniser resets to zero, so reset reads as all asserted
	assign hold_s  = ~ctl_s[2];
	assign float_s = ~ctl_s[1];
	assign crst_s  = ~ctl_s[0];

	// ------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------
	state_t   state_r;
	state_t   state_nxt;
	bus_req_t acc_r;
	bus_req_t cur;
	logic [3:0] cnt_r;
	logic     accept;
	logic     finish;
	logic     drive_nxt;
	logic     float_nxt;

	assign accept = (state_r == st_idle) && req_valid && req_ready
		&& !hold_s && !crst_s;
	assign finish = (state_r == st_access) && (cnt_r == 4'h0);
	assign cur    = accept ? req : acc_r;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			st_idle:
			begin
				if (hold_s)
					state_nxt = st_hold;
				else if (accept)
					state_nxt = st_access;
			end
			st_access:
			begin
				// Chip reset abandons the cycle
				if (crst_s || finish)
					state_nxt = st_idle;
			end
			st_hold:
			begin
				if (!hold_s)
					state_nxt = st_idle;
			end
			default:
				state_nxt = st_idle;
		endcase
	end

	assign drive_nxt = (state_nxt == st_access);
	assign float_nxt = (state_nxt == st_hold) || float_s;

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			state_r <= st_idle;
		else if (ce)
			state_r <= state_nxt;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_r <= '0;
			cnt_r <= 4'h0;
		end
		else if (ce)
		begin
			if (accept)
			begin
				acc_r <= req;
				cnt_r <= 4'(ACCESS_CYCLES - 1);
			end
			else if (cnt_r != 4'h0)
				cnt_r <= cnt_r - 4'h1;
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			req_ready <= 1'b0;
			rd_valid  <= 1'b0;
			rd_data   <= '0;
		end
		else if (ce)
		begin
			req_ready <= (state_nxt == st_idle) && !hold_s && !crst_s;
			rd_valid  <= finish && !crst_s && !acc_r.write;
			if (finish && !acc_r.write)
				rd_data <= data_s;
		end
	end

	// ------------------------------------------------------------
	// Address, data and control pins
	// ------------------------------------------------------------
	// All drive changes are registered here, on clock edges, except the clear that rstn applies at once
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			addr_lo_out <= '0;
			addr_hi_out <= HI_IDLE;
			addr_lo_oe  <= 1'b0;
			addr_hi_oe  <= 1'b0;
		end
		else if (ce)
		begin
			addr_lo_out <= cur.addr[LO_W-1:0];
			if (drive_nxt && cur.space == space_prog)
				addr_hi_out <= cur.addr[ADDR_W-1:LO_W];
			else
				addr_hi_out <= HI_IDLE;
			addr_lo_oe  <= !float_nxt;
			addr_hi_oe  <= !float_nxt;
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			data_out <= '0;
			data_oe  <= 1'b0;
		end
		else if (ce)
		begin
			data_out <= cur.wdata;
			data_oe  <= drive_nxt && cur.write && !float_nxt
				&& !crst_s && !hold_s;
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_accept_n  <= 1'b1;
			irq_accept_oe <= 1'b0;
			bus_grant_n   <= 1'b1;
			bus_grant_oe  <= 1'b0;
		end
		else if (ce)
		begin
			irq_accept_n  <= !(drive_nxt && cur.vector);
			irq_accept_oe <= !float_s;
			// Outside master waits for this before using the bus
			bus_grant_n   <= !(state_nxt == st_hold);
			bus_grant_oe  <= !float_s;
		end
	end

	// ------------------------------------------------------------
	// Data bus keepers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			bus_keeper_enable <= KEEPER_RESET;
		else if (ce && bank_switch_wr)
			bus_keeper_enable <= bank_switch_keeper;
	end

	// Keeper echoes its own level back through the pins, so it
	// freezes its value instead of tracking the sampled pin
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			keep_out <= '0;
			keep_en  <= 1'b0;
		end
		else if (ce)
		begin
			if (data_oe)
				keep_out <= data_out;
			else if (!keep_en)
				keep_out <= data_s;
			keep_en <= bus_keeper_enable && !(drive_nxt && cur.write
				&& !float_nxt && !crst_s && !hold_s);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_hold_addr_float: assert property (@(posedge clock) disable iff (!rstn)
		(state_r == st_hold) |-> !addr_lo_oe && !addr_hi_oe)
		else $error("address driven during hold");

	a_off_float_all: assert property (@(posedge clock) disable iff (!rstn)
		(ce && float_s) |=> !addr_lo_oe && !irq_accept_oe && !data_oe)
		else $error("pins driven while output float is low");

	a_data_rst_float: assert property (@(posedge clock) disable iff (!rstn)
		(ce && (crst_s || hold_s)) |=> !data_oe)
		else $error("data driven under reset or hold request");

	a_data_write_only: assert property (@(posedge clock) disable iff (!rstn)
		data_oe |-> (state_r == st_access) && acc_r.write)
		else $error("data driven outside a write");

	a_hi_prog_only: assert property (@(posedge clock) disable iff (!rstn)
		(addr_hi_out != HI_IDLE) |->
		(state_r == st_access) && (acc_r.space == space_prog))
		else $error("upper address used outside program space");

	a_irq_vector_addr: assert property (@(posedge clock) disable iff (!rstn)
		!irq_accept_n |-> (state_r == st_access) && acc_r.vector
		&& (addr_lo_out == acc_r.addr[LO_W-1:0]))
		else $error("interrupt accept without vector address");

	a_grant_floated: assert property (@(posedge clock) disable iff (!rstn)
		!bus_grant_n |-> !addr_lo_oe && !data_oe)
		else $error("grant while bus lines driven");

	a_keeper_off: assert property (@(posedge clock) disable iff (!rstn)
		(ce && !bus_keeper_enable) |=> !keep_en)
		else $error("keeper active while disabled");

	a_keeper_hold: assert property (@(posedge clock) disable iff (!rstn)
		(ce && keep_en && !data_oe) |=> keep_out == $past(keep_out))
		else $error("keeper level changed while holding");

	a_read_timing: assert property (@(posedge clock) disable iff (!rstn)
		(ce && accept && !req.write) ##1 (ce && !crst_s) [*3]
		|=> rd_valid)
		else $error("read answer not on time");

endmodule

// *** common/ext_bus_pkg.sv ***
package ext_bus_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 20;
	localparam int LO_W   = 16;
	localparam int HI_W   = ADDR_W - LO_W;
	localparam int DATA_W = 16;

	// ------------------------------------------------------------
	// Timing and reset values
	// ------------------------------------------------------------
	localparam int       SYNC_STAGES   = 2;
	localparam int       ACCESS_CYCLES = 3;
	localparam logic     KEEPER_RESET  = 1'b0;
	localparam logic [HI_W-1:0] HI_IDLE = 4'h0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {space_prog, space_data, space_io} space_t;

	typedef struct packed {
		space_t              space;
		logic                write;
		logic                vector;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
	} bus_req_t;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync
	import ext_bus_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_r;

	initial
	begin
		if (WIDTH < 1)
			$error("pin_sync width must be at least one");
	end

	// First stage feeds only the second
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= '0;
			dout   <= '0;
		end
		else if (ce)
		begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule

// *** tb/ext_mem_model.sv ***
`timescale 1ns/1ns
module ext_mem_model
	import ext_bus_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              sel,
	input  wire logic              want_bus,
	input  wire logic [LO_W-1:0]   addr_lo_out,
	input  wire logic [DATA_W-1:0] data_out,
	input  wire logic              data_oe,
	input  wire logic [DATA_W-1:0] keep_out,
	input  wire logic              keep_en,
	output logic [DATA_W-1:0]      data_pin,
	output logic                   hold_req_n
);
	logic [DATA_W-1:0] last_r = 16'h0000;

	// --------------------------------------------
	// Wire resolution
	// --------------------------------------------
	// No pull on the bus: a released line must not show a stale value
	always_comb
	begin
		if (data_oe)
			data_pin = data_out;
		else if (sel)
			data_pin = addr_lo_out ^ 16'h5a5a;
		else if (keep_en)
			data_pin = keep_out;
		else
			data_pin = ~last_r;
	end

	always_ff @(posedge clock)
		last_r <= data_pin;

	assign hold_req_n = ~want_bus;
endmodule

// *** tb/ext_bus_pins_test.sv ***
`timescale 1ns/1ns
module ext_bus_pins_test
	import ext_bus_pkg::*;
;
	typedef struct {
		space_t      sp;
		logic        wr;
		logic        vec;
		logic [19:0] a;
		logic [15:0] wd;
	} row_t;

	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic sel = 1'b0;
	logic want_bus = 1'b0;
	bus_req_t req = '0;
	logic req_valid = 1'b0;
	logic bs_wr = 1'b0;
	logic bs_keep = 1'b0;
	logic float_n = 1'b1;
	logic crst_n = 1'b1;
	logic ce = 1'b1;
	logic req_ready, rd_valid, bus_keeper_enable, hold_req_n;
	logic addr_lo_oe, addr_hi_oe, data_oe, keep_en;
	logic irq_accept_n, irq_accept_oe, bus_grant_n, bus_grant_oe;
	logic [15:0] rd_data, data_out, keep_out, data_pin, addr_lo_out;
	logic [3:0] addr_hi_out;
	int n_fail = 0;
	int checks_done = 0;
	row_t rows[7];

	always #5 clock = ~clock;

	ext_bus_pins i_ext_bus_pins (.clock(clock), .rstn(rstn), .ce(ce),
		.req(req), .req_valid(req_valid), .req_ready(req_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .bank_switch_wr(bs_wr),
		.bank_switch_keeper(bs_keep), .bus_keeper_enable(bus_keeper_enable),
		.hold_req_n(hold_req_n), .output_float_n(float_n),
		.chip_reset_n(crst_n), .data_in(data_pin),
		.addr_lo_out(addr_lo_out), .addr_lo_oe(addr_lo_oe),
		.addr_hi_out(addr_hi_out), .addr_hi_oe(addr_hi_oe),
		.data_out(data_out), .data_oe(data_oe), .keep_out(keep_out),
		.keep_en(keep_en), .irq_accept_n(irq_accept_n),
		.irq_accept_oe(irq_accept_oe), .bus_grant_n(bus_grant_n),
		.bus_grant_oe(bus_grant_oe));

	ext_mem_model i_ext_mem_model (.clock(clock), .sel(sel),
		.want_bus(want_bus), .addr_lo_out(addr_lo_out),
		.data_out(data_out), .data_oe(data_oe), .keep_out(keep_out),
		.keep_en(keep_en), .data_pin(data_pin), .hold_req_n(hold_req_n));

	// --------------------------------------------
	// Helpers
	// --------------------------------------------
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic finish_test;
		$display("checks %0d, failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Waits for an idle bus, makes one access and checks its pins
	task automatic run_row(input row_t r);
		int n;
		logic [3:0] hi_exp;
		n = 0;
		hi_exp = (r.sp == space_prog) ? r.a[19:16] : 4'h0;
		while (req_ready !== 1'b1 && n < 50)
		begin
			cyc(1);
			n++;
		end
		sel = ~r.wr;
		req = '{space:r.sp, write:r.wr, vector:r.vec, addr:r.a, wdata:r.wd};
		req_valid = 1'b1;
		cyc(1);
		req_valid = 1'b0;
		chk(addr_lo_out === r.a[15:0] && addr_lo_oe === 1'b1, "lo");
		chk(addr_hi_out === hi_exp, "hi");
		chk(irq_accept_n === ~r.vec && irq_accept_oe === 1'b1, "ack");
		chk(data_oe === r.wr, "data drive");
		if (r.wr)
			chk(data_out === r.wd, "wdata");
		n = 0;
		while (!r.wr && rd_valid !== 1'b1 && n < 10)
		begin
			cyc(1);
			n++;
		end
		if (!r.wr)
		begin
			chk(rd_valid === 1'b1 && n == ACCESS_CYCLES, "read time");
			chk(rd_data === (r.a[15:0] ^ 16'h5a5a), "rdata");
			chk(irq_accept_n === 1'b1 && addr_hi_out === 4'h0, "end");
		end
		sel = 1'b0;
		cyc(4);
		chk(data_oe === 1'b0, "data released");
	endtask

	// --------------------------------------------
	// Sequence
	// --------------------------------------------
	initial
	begin
		rows = '{'{space_prog, 0, 0, 20'ha1234, 0},
			'{space_data, 0, 0, 20'hf00ff, 0},
			'{space_io, 0, 0, 20'h3ffff, 0},
			'{space_prog, 0, 1, 20'hfff80, 0},
			'{space_data, 1, 0, 20'h50001, 16'hbeef},
			'{space_io, 1, 0, 20'h8a5a5, 16'h0f0f},
			'{space_prog, 1, 0, 20'hc8000, 16'h7e81}};
		cyc(20);
		rstn = 1'b1;
		cyc(5);
		chk(bus_keeper_enable === 1'b0 && keep_en === 1'b0, "keep rst");
		$display("test reset done");
		foreach (rows[i])
			run_row(rows[i]);
		$display("test accesses done");
		ce = 1'b0;
		want_bus = 1'b1;
		cyc(6);
		chk(bus_grant_n === 1'b1 && req_ready === 1'b1, "ce freeze");
		ce = 1'b1;
		cyc(5);
		chk(bus_grant_n === 1'b0 && bus_grant_oe === 1'b1, "grant");
		chk({addr_lo_oe, addr_hi_oe, data_oe} === 3'b000, "hold");
		chk(req_ready === 1'b0, "hold busy");
		want_bus = 1'b0;
		cyc(5);
		chk(bus_grant_n === 1'b1 && addr_lo_oe === 1'b1, "unhold");
		$display("test hold done");
		float_n = 1'b0;
		cyc(5);
		chk({addr_lo_oe, addr_hi_oe} === 2'b00, "float addr");
		chk(data_oe === 1'b0, "float data");
		chk(irq_accept_oe === 1'b0 && bus_grant_oe === 1'b0, "float ack");
		float_n = 1'b1;
		cyc(5);
		$display("test float done");
		bs_keep = 1'b1;
		bs_wr = 1'b1;
		cyc(1);
		bs_wr = 1'b0;
		cyc(3);
		chk(bus_keeper_enable === 1'b1 && keep_en === 1'b1, "keep on");
		run_row('{space_data, 1, 0, 20'h00042, 16'h1234});
		chk(data_pin === 16'h1234, "keeper level");
		$display("test keeper done");
		crst_n = 1'b0;
		cyc(5);
		chk(req_ready === 1'b0 && data_oe === 1'b0, "chip reset");
		crst_n = 1'b1;
		cyc(5);
		$display("test chip reset done");
		finish_test();
	end

	initial
	begin
		#20000;
		n_fail++;
		finish_test();
	end
endmodule
